// File: core/fsp_ctrl.sv
/*
 pin control of a flow-through burst sram: selection, burst counter, output
 enable masking, clock qualification, sleep, byte/parity writes.
 assumes controller-driven inputs synchronous to i_sys_clk; i_rst_n gives defined state.
*/
// Behaviour
// - third chip select, active low, sampled each edge and combined for selection.
// - output enable low with internal permission lets data and parity pins drive.
// - output enable high keeps data and parity pins undriven, inputs only.
// - outputs off during write data phase, first clock after deselect, while deselected.
// - edges with clock qualify high are ignored; all state except the sleep flag held.
// - clock qualify high does not deselect; previous operation and outputs persist.
// - sleep enters low power and keeps memory contents intact; a pending write keeps writing its address on each qualified edge.
// - input data captured into data register on the rising edge.
// - read drives location addressed at that edge, flow-through without output register.
// - parity lanes act as data lanes, written under their byte write select.
// - burst order strap low gives linear order, high gives interleaved.
// - second chip select is active high, sampled with the others.
// - access starts only with all three selects active at a qualified edge.
// - low two address bits load the two-bit burst counter.
// - advance-or-load high advances counter, low loads new address.
`timescale 1ns/1ps
`default_nettype none
module fsp_ctrl (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_clk_en,
    input wire logic i_chip_select_first_n,
    input wire logic i_chip_select_second,
    input wire logic i_chip_select_third_n,
    input wire logic i_clock_qualify_n,
    input wire logic i_advance_or_load,
    input wire logic i_write_n,
    input wire logic [fsp_pkg::BYTES-1:0] i_byte_write_sel_n,
    input wire logic [fsp_pkg::ADDR_W-1:0] i_addr,
    input wire logic i_output_enable_n,
    input wire logic i_sleep_request,
    input wire logic i_burst_order,
    input wire logic [fsp_pkg::DATA_W-1:0] i_data,
    output logic [fsp_pkg::DATA_W-1:0] o_data,
    output logic o_data_oe,
    input wire logic [fsp_pkg::BYTES-1:0] i_parity_lane_io,
    output logic [fsp_pkg::BYTES-1:0] o_parity_lane_io,
    output logic [fsp_pkg::BYTES-1:0] o_parity_lane_oe,
    output logic o_sleeping
);
    ////////////////////////////////////////////////////////////////////////
    fsp_mem_if mi ();
    fsp_mem u_mem (
        .i_sys_clk(i_sys_clk),
        .m(mi.mem)
    );

    fsp_pkg::fsp_op_t op_r, op_nxt;
    logic [fsp_pkg::ADDR_W-1:0] base_r, base_nxt;
    logic [1:0] cnt_r, cnt_nxt;
    logic [1:0] start_r, start_nxt;
    logic [fsp_pkg::BYTES-1:0] bw_n_r, bw_n_nxt;
    logic first_r, first_nxt;
    logic [fsp_pkg::DATA_W-1:0] wdata_r;
    logic [fsp_pkg::BYTES-1:0] wpar_r;
    logic sleep_r;

    ////////////////////////////////////////////////////////////////////////
    // qualified edge: block enable high and clock qualify low
    wire adv = i_clk_en & ~i_clock_qualify_n;
    wire step = i_clk_en & ~i_clock_qualify_n & ~i_sleep_request;
    wire selected = ~i_chip_select_first_n & i_chip_select_second & ~i_chip_select_third_n;
    wire load = step & ~i_advance_or_load;
    wire start = load & selected;
    wire burst = step & i_advance_or_load & (op_r != fsp_pkg::FSP_DESEL);
    wire [1:0] cnt_inc = cnt_r + fsp_pkg::BURST_STEP;
    // linear increments from the start, interleaved xors the step count in
    wire [1:0] lin_nxt = cnt_inc;
    wire [1:0] ilv_nxt = start_r ^ (cnt_r ^ start_r) + fsp_pkg::BURST_STEP;
    wire [1:0] seq_nxt = i_burst_order ? ilv_nxt : lin_nxt;
    wire [fsp_pkg::ADDR_W-1:0] cur_addr = {base_r[fsp_pkg::ADDR_W-1:2], cnt_r};

    always_comb begin
        op_nxt = op_r;
        base_nxt = base_r;
        cnt_nxt = cnt_r;
        start_nxt = start_r;
        bw_n_nxt = bw_n_r;
        first_nxt = first_r;
        if (load) begin
            first_nxt = (op_r == fsp_pkg::FSP_DESEL) & selected;
            if (start) begin
                op_nxt = i_write_n ? fsp_pkg::FSP_READ : fsp_pkg::FSP_WRITE;
                base_nxt = i_addr;
                cnt_nxt = i_addr[1:0];
                start_nxt = i_addr[1:0];
                bw_n_nxt = i_byte_write_sel_n;
            end else begin
                op_nxt = fsp_pkg::FSP_DESEL;
            end
        end else if (burst) begin
            cnt_nxt = seq_nxt;
            bw_n_nxt = i_byte_write_sel_n;
            first_nxt = 1'b0;
        end else if (step) begin
            first_nxt = 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            op_r <= fsp_pkg::FSP_DESEL;
            base_r <= '0;
            cnt_r <= fsp_pkg::BURST_INIT;
            start_r <= fsp_pkg::BURST_INIT;
            bw_n_r <= fsp_pkg::BW_NONE_N;
            first_r <= 1'b0;
        end else if (step) begin
            op_r <= op_nxt;
            base_r <= base_nxt;
            cnt_r <= cnt_nxt;
            start_r <= start_nxt;
            bw_n_r <= bw_n_nxt;
            first_r <= first_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // write data is taken one edge after the write command
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            wdata_r <= fsp_pkg::DATA_RST;
            wpar_r <= fsp_pkg::PAR_RST;
        end else if (adv) begin
            if (op_r == fsp_pkg::FSP_WRITE) begin
                wdata_r <= i_data;
                wpar_r <= i_parity_lane_io;
            end
        end
    end

    wire wr_now = adv & (op_r == fsp_pkg::FSP_WRITE);
    assign mi.addr = cur_addr;
    assign mi.wdata = i_data;
    assign mi.wpar = i_parity_lane_io;
    assign mi.we = wr_now ? ~bw_n_r : '0;

    ////////////////////////////////////////////////////////////////////////
    // read data follows the current address, held while edges are masked
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            sleep_r <= 1'b0;
        end else if (i_clk_en) begin
            sleep_r <= i_sleep_request;
        end
    end

    wire drive_ok = (op_r == fsp_pkg::FSP_READ) & ~first_r & ~sleep_r;
    assign o_data_oe = drive_ok & ~i_output_enable_n;
    assign o_parity_lane_oe = {fsp_pkg::BYTES{o_data_oe}};
    assign o_data = mi.rdata;
    assign o_parity_lane_io = mi.rpar;
    assign o_sleeping = sleep_r;

    ////////////////////////////////////////////////////////////////////////
    chk_oe_high_off: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        i_output_enable_n |-> !o_data_oe) else $error("pins driven with output enable high");
    chk_write_no_drive: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (op_r == fsp_pkg::FSP_WRITE) |-> !o_data_oe) else $error("pins driven during write");
    chk_masked_hold: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_rst_n && i_clock_qualify_n) |=> $stable(op_r) && $stable(cnt_r)) else $error("state moved on masked edge");
    chk_start_sel: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (step && !i_advance_or_load && !selected) |=> op_r == fsp_pkg::FSP_DESEL) else $error("access without select");
    chk_load_count: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        start |=> cnt_r == $past(i_addr[1:0])) else $error("counter not loaded");
    sequence s_lin_burst;
        step && i_advance_or_load && !i_burst_order && op_r != fsp_pkg::FSP_DESEL;
    endsequence
    chk_lin_adv: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        s_lin_burst |=> cnt_r == 2'($past(cnt_r) + 2'h1)) else $error("linear step wrong");
    chk_sleep_idle: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        i_sleep_request |=> $stable(op_r)) else $error("command taken while sleeping");
    chk_byte_gate: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (mi.we & bw_n_r) == '0) else $error("unselected byte written");
    chk_first_off: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (start && op_r == fsp_pkg::FSP_DESEL) |=> !o_data_oe) else $error("drove on first clock after deselect");

    ////////////////////////////////////////////////////////////////////////
    // read drive, selection polarity, freeze, interleaved burst, write data and address load checks
    chk_read_drive: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (op_r == fsp_pkg::FSP_READ && !first_r && !sleep_r && !i_output_enable_n)
        |-> o_data_oe) else $error("read data not driven");

    chk_desel_off: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (op_r == fsp_pkg::FSP_DESEL)
        |-> !o_data_oe) else $error("pins driven while deselected");

    chk_third_sel: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (step && !i_advance_or_load && i_chip_select_third_n)
        |=> op_r == fsp_pkg::FSP_DESEL) else $error("third select ignored");

    chk_second_sel: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (step && !i_advance_or_load && !i_chip_select_second)
        |=> op_r == fsp_pkg::FSP_DESEL) else $error("second select ignored");

    chk_enable_hold: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        !i_clk_en
        |=> $stable(op_r) && $stable(cnt_r) && $stable(sleep_r)) else $error("state moved while disabled");

    sequence s_ilv_burst;
        step && i_advance_or_load && i_burst_order && op_r != fsp_pkg::FSP_DESEL;
    endsequence

    chk_ilv_adv: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        s_ilv_burst
        |=> (cnt_r ^ start_r) == 2'(($past(cnt_r) ^ $past(start_r)) + 2'h1)) else $error("interleaved step wrong");

    chk_data_capture: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (adv && op_r == fsp_pkg::FSP_WRITE)
        |=> wdata_r == $past(i_data) && wpar_r == $past(i_parity_lane_io)) else $error("write data not captured");

    chk_write_lanes: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (adv && op_r == fsp_pkg::FSP_WRITE)
        |-> mi.we == ~bw_n_r) else $error("selected byte not written");

    chk_load_base: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        start
        |=> base_r == $past(i_addr)) else $error("address not latched");
endmodule : fsp_ctrl
`default_nettype wire

// File: core/fsp_pkg.sv
/*
 constants and types for the flow-through sram pin control block.
 assumes nothing beyond a systemverilog compiler.
*/
package fsp_pkg;
    localparam int ADDR_W = 17;
    localparam int BYTES = 4;
    localparam int DATA_W = 32;
    localparam int DEPTH = 131072;
    localparam int BURST_W = 2;
    localparam logic [1:0] BURST_INIT = 2'h0;
    localparam logic [1:0] BURST_STEP = 2'h1;
    localparam logic [3:0] BW_NONE_N = 4'hf;
    localparam logic [31:0] DATA_RST = 32'h0;
    localparam logic [3:0] PAR_RST = 4'h0;
    typedef enum logic [2:0] {
        FSP_DESEL = 3'b001,
        FSP_READ = 3'b010,
        FSP_WRITE = 3'b100
    } fsp_op_t;
endpackage : fsp_pkg

// File: core/fsp_mem_if.sv
/*
 carrier between the control and the array.
 assumes one clock shared by both ends.
*/
`timescale 1ns/1ps
`default_nettype none
interface fsp_mem_if;
    logic [fsp_pkg::ADDR_W-1:0] addr;
    logic [fsp_pkg::BYTES-1:0] we;
    logic [fsp_pkg::DATA_W-1:0] wdata;
    logic [fsp_pkg::BYTES-1:0] wpar;
    logic [fsp_pkg::DATA_W-1:0] rdata;
    logic [fsp_pkg::BYTES-1:0] rpar;
    modport ctrl (output addr, output we, output wdata, output wpar, input rdata, input rpar);
    modport mem (input addr, input we, input wdata, input wpar, output rdata, output rpar);
endinterface : fsp_mem_if
`default_nettype wire

// File: core/fsp_mem.sv
/*
 the storage array: per-byte write enables, data and parity lanes together.
 assumes synchronous clock; contents survive sleep since it is never cleared.
*/
`timescale 1ns/1ps
`default_nettype none
module fsp_mem (
    input wire logic i_sys_clk,
    fsp_mem_if.mem m
);
    logic [8:0] arr_r [0:fsp_pkg::DEPTH-1][0:fsp_pkg::BYTES-1];
    // combinational read so the array acts flow-through behind the address register
    for (genvar b = 0; b < fsp_pkg::BYTES; b++) begin : g_lane
        always_ff @(posedge i_sys_clk) begin
            if (m.we[b]) begin
                arr_r[m.addr][b] <= {m.wpar[b], m.wdata[8*b +: 8]};
            end
        end
        assign m.rdata[8*b +: 8] = arr_r[m.addr][b][7:0];
        assign m.rpar[b] = arr_r[m.addr][b][8];
    end
endmodule : fsp_mem
`default_nettype wire

// File: verification/fsp_host_model.sv
/*
 memory controller model driving the pins of the sram pin control.
 assumes the bench calls step once per clock cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module fsp_host_model (
    input wire logic i_clk,
    output logic [2:0] o_sel,
    output logic [3:0] o_ctl,
    output logic [3:0] o_bw_n,
    output logic [fsp_pkg::ADDR_W-1:0] o_addr,
    output logic [35:0] o_wd
);
    initial begin
        o_sel = 3'h3;
        o_ctl = 4'h2;
        o_bw_n = 4'hf;
        o_addr = '0;
        o_wd = '0;
    end
    // sel is {third_n, second, first_n}; ctl is {qualify_n, advance, write_n, oe_n}
    task step(input logic [2:0] s, input logic [3:0] c, input logic [3:0] b,
              input logic [16:0] a, input logic dv, input logic [35:0] d);
        @(posedge i_clk);
        o_sel <= s;
        o_ctl <= c;
        o_bw_n <= b;
        o_addr <= a;
        // released lanes never keep their last value
        o_wd <= dv ? d : ~o_wd;
    endtask : step
endmodule : fsp_host_model
`default_nettype wire

// File: verification/tb_top.sv
/*
 self-checking bench for the sram pin control.
 assumes fsp_ctrl holds the array and the host model drives the pins.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam logic [2:0] ON = 3'h2;
    localparam logic [2:0] OFF = 3'h3;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic sleep_req = 1'b0;
    logic order = 1'b0;
    int n_errors = 0;
    int check_count = 0;
    logic [2:0] sel;
    logic [3:0] ctl, bw_n, par, par_oe;
    logic [16:0] addr;
    logic [35:0] wd;
    logic [31:0] rdat;
    logic oe, slp;
    fsp_host_model m (.i_clk(clk), .o_sel(sel), .o_ctl(ctl), .o_bw_n(bw_n), .o_addr(addr), .o_wd(wd));
    fsp_ctrl dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_clk_en(1'b1), .i_chip_select_first_n(sel[0]),
        .i_chip_select_second(sel[1]), .i_chip_select_third_n(sel[2]), .i_clock_qualify_n(ctl[3]),
        .i_advance_or_load(ctl[2]), .i_write_n(ctl[1]), .i_byte_write_sel_n(bw_n), .i_addr(addr),
        .i_output_enable_n(ctl[0]), .i_sleep_request(sleep_req), .i_burst_order(order),
        .i_data(wd[31:0]), .o_data(rdat), .o_data_oe(oe), .i_parity_lane_io(wd[35:32]),
        .o_parity_lane_io(par), .o_parity_lane_oe(par_oe), .o_sleeping(slp));
    initial forever #2 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [35:0] w(input int i);
        return {i[3:0], {8{i[3:0]}}};
    endfunction : w
    task chk(input logic [35:0] got, input logic [35:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task wr(input int a, input logic [3:0] b, input logic [35:0] d);
        m.step(ON, 4'h0, b, a[16:0], 1'b0, '0);
        m.step(OFF, 4'h2, 4'hf, '0, 1'b1, d);
        #1 chk(36'({par_oe, oe}), '0);
    endtask : wr
    task rd(input int a, input logic [35:0] exp);
        m.step(ON, 4'h2, 4'hf, a[16:0], 1'b0, '0);
        m.step(OFF, 4'h2, 4'hf, '0, 1'b0, '0);
        #1 chk({par, rdat}, exp);
    endtask : rd
    ////////////////////////////////////////////////////////////////////////////
    task t_rw;
        for (int i = 4; i < 8; i++) wr(i, 4'h0, w(i));
        rd(5, w(5));
        wr(5, 4'he, 36'hf_ffff_ffff);
        rd(5, w(5) | 36'h1_0000_00ff);
        wr(5, 4'h0, w(5));
    endtask : t_rw
    task t_sel;
        for (int i = 0; i < 3; i++) begin
            m.step(ON ^ (3'h1 << i), 4'h0, 4'h0, 17'h6, 1'b0, '0);
            m.step(OFF, 4'h2, 4'hf, '0, 1'b1, '0);
            rd(6, w(6));
        end
    endtask : t_sel
    task t_burst(input logic mode);
        @(posedge clk) order <= mode;
        m.step(ON, 4'h2, 4'hf, 17'h5, 1'b0, '0);
        m.step(ON, 4'h6, 4'hf, '0, 1'b0, '0);
        #1 chk(36'({par_oe, oe}), '0);
        chk({par, rdat}, w(5));
        m.step(ON, 4'h6, 4'hf, '0, 1'b0, '0);
        #1 chk(36'({par_oe, oe}), 36'h1f);
        chk({par, rdat}, mode ? w(4) : w(6));
        m.step(ON, 4'h7, 4'hf, '0, 1'b0, '0);
        #1 chk(36'({par_oe, oe}), '0);
        chk({par, rdat}, w(7));
        m.step(OFF, 4'h2, 4'hf, '0, 1'b0, '0);
    endtask : t_burst
    task t_hold;
        m.step(ON, 4'h2, 4'hf, 17'h6, 1'b0, '0);
        m.step(ON, 4'h6, 4'hf, '0, 1'b0, '0);
        for (int i = 0; i < 2; i++) begin
            m.step(OFF, 4'ha, 4'h0, '0, 1'b0, '0);
            #1 chk(36'({par_oe, oe}), 36'h1f);
            chk({par, rdat}, w(7));
        end
        m.step(OFF, 4'h2, 4'hf, '0, 1'b0, '0);
    endtask : t_hold
    task t_sleep;
        @(posedge clk) sleep_req <= 1'b1;
        wr(4, 4'h0, '0);
        chk(36'(slp), 36'h1);
        @(posedge clk) sleep_req <= 1'b0;
        rd(4, w(4));
        chk(36'(slp), '0);
    endtask : t_sleep
    task stop_test;
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : stop_test
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        t_rw;
        t_sel;
        t_burst(1'b0);
        t_burst(1'b1);
        t_hold;
        t_sleep;
        stop_test;
    end
endmodule : tb_top
`default_nettype wire
